// ==== design/lwd_pkg.sv ====
package lwd_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_IO_DIS_LO  = 8'h20;
  localparam logic [7:0] OFF_IO_DIS_HI  = 8'h24;
  localparam logic [7:0] OFF_PRESET     = 8'h30;
  localparam logic [7:0] OFF_MEM_DIS_LO = 8'h40;
  localparam logic [7:0] OFF_MEM_DIS_HI = 8'h44;
  localparam logic [7:0] OFF_HOST_BASE  = 8'h50;
  localparam logic [7:0] OFF_CFG        = 8'hFC;

  // Reset values
  localparam logic [63:0] RST_DIS    = 64'h0000_0000_0000_0000;
  localparam logic [15:0] RST_PRESET = 16'h002E;
  localparam logic [31:0] RST_CFG    = 32'h0000_0000;
  localparam logic [31:0] RST_HBASE  = 32'h0000_0000;

  // Window configuration field positions
  localparam int CFG_BASE_LSB  = 8;
  localparam int CFG_INHIBIT   = 7;
  localparam int CFG_SIZE_LSB  = 0;
  localparam int CFG_SIZE_W    = 4;
  localparam int BASE_SHIFT    = 8;
  localparam logic [3:0] SIZE_MAX = 4'hC;
  localparam logic [31:0] CFG_WMASK = 32'hFFFF_FF8F;

  // Window translation request and answer
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } lwd_mreq_t;

  typedef struct packed {
    logic        claim;
    logic [31:0] ahb_addr;
  } lwd_mrsp_t;

endpackage

// ==== design/lwd_decode_ctrl.sv ====
`timescale 1ns/1ps
// Functional notes
// - I/O disable bit set stops that device's I/O base from claiming.
// - I/O disable bit i controls logical device i, bits 0 to 63.
// - Memory disable bit set stops that device's memory base claiming.
// - Memory disable bit clear leaves claiming to the valid flag.
// - Memory disable bits of reserved devices stay RW, no decode effect.
// - Host-side reset copies preset (default 002Eh) into base at 60h.
// - AHB base field shifted left eight gives 256-byte aligned region.
// - Inhibit bit set refuses host access to the mapped region.
// - Size N (0 to 12) passes lowest N address bits, a 2^N-byte region; larger sizes never claim.
module lwd_decode_ctrl #(
  parameter int NUM_DEV = 64
) (
  // Clock and reset
  input  wire logic                  CORE_CLK_I,
  input  wire logic                  RST_I,
  input  wire logic                  HOST_RESET_N_I,
  // Avalon-MM slave
  input  wire logic [7:0]            AVS_ADDRESS_I,
  input  wire logic                  AVS_READ_I,
  input  wire logic                  AVS_WRITE_I,
  input  wire logic [31:0]           AVS_WRITEDATA_I,
  input  wire logic [3:0]            AVS_BYTEENABLE_I,
  output logic [31:0]                AVS_READDATA_O,
  output logic                       AVS_WAITREQUEST_O,
  // Base register valid flags and device present flags
  input  wire logic [NUM_DEV-1:0]    IO_VALID_I,
  input  wire logic [NUM_DEV-1:0]    MEM_VALID_I,
  input  wire logic [NUM_DEV-1:0]    DEV_PRESENT_I,
  // Gated claim enables
  output logic [NUM_DEV-1:0]         IO_CLAIM_EN_O,
  output logic [NUM_DEV-1:0]         MEM_CLAIM_EN_O,
  // Configuration port base load
  output logic                       CFG_BASE_LOAD_O,
  output logic [15:0]                CFG_BASE_VAL_O,
  // Memory window translation
  input  wire lwd_pkg::lwd_mreq_t    MEM_REQ_I,
  output lwd_pkg::lwd_mrsp_t         MEM_RSP_O
);

  // Elaboration check: the mask registers hold at most 64 devices
  if (NUM_DEV < 32 || NUM_DEV > 64) begin : g_bad_num_dev
    $error("NUM_DEV must lie in 32..64");
  end

  logic [63:0] io_dis_q;
  logic [63:0] mem_dis_q;
  logic [15:0] preset_q;
  logic [31:0] cfg_q;
  logic [31:0] hbase_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [1:0]  hrst_q;
  logic        load_q;
  logic [15:0] load_val_q;
  lwd_pkg::lwd_mrsp_t rsp_q;

  // Bus decode
  wire        acc     = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  // A write lands at the edge where waitrequest is seen low
  wire        wr_stb  = AVS_WRITE_I & ack_q;
  wire        rd_stb  = AVS_READ_I & ~ack_q;
  wire        sel_iol = AVS_ADDRESS_I == lwd_pkg::OFF_IO_DIS_LO;
  wire        sel_ioh = AVS_ADDRESS_I == lwd_pkg::OFF_IO_DIS_HI;
  wire        sel_pre = AVS_ADDRESS_I == lwd_pkg::OFF_PRESET;
  wire        sel_mml = AVS_ADDRESS_I == lwd_pkg::OFF_MEM_DIS_LO;
  wire        sel_mmh = AVS_ADDRESS_I == lwd_pkg::OFF_MEM_DIS_HI;
  wire        sel_hb  = AVS_ADDRESS_I == lwd_pkg::OFF_HOST_BASE;
  wire        sel_cfg = AVS_ADDRESS_I == lwd_pkg::OFF_CFG;
  wire [31:0] be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                         {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // Preset write data, merged before the part-select
  wire [31:0] pre_mrg = merge({16'h0000, preset_q}, AVS_WRITEDATA_I,
                              be_mask);

  // Read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
      sel_iol ? io_dis_q[31:0]  :
      sel_ioh ? io_dis_q[63:32] :
      sel_pre ? {16'h0000, preset_q} :
      sel_mml ? mem_dis_q[31:0]  :
      sel_mmh ? mem_dis_q[63:32] :
      sel_hb  ? hbase_q :
      sel_cfg ? (cfg_q & lwd_pkg::CFG_WMASK) : 32'h0000_0000;

  // One wait state per access, answer on the following edge
  assign AVS_WAITREQUEST_O = acc;
  assign AVS_READDATA_O    = rdata_q;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      if (rd_stb) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Mask and window registers, system reset
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      io_dis_q  <= lwd_pkg::RST_DIS;
      mem_dis_q <= lwd_pkg::RST_DIS;
      cfg_q     <= lwd_pkg::RST_CFG;
      hbase_q   <= lwd_pkg::RST_HBASE;
    end else if (wr_stb) begin
      if (sel_iol) io_dis_q[31:0]  <= merge(io_dis_q[31:0],
                                            AVS_WRITEDATA_I, be_mask);
      if (sel_ioh) io_dis_q[63:32] <= merge(io_dis_q[63:32],
                                            AVS_WRITEDATA_I, be_mask);
      if (sel_mml) mem_dis_q[31:0]  <= merge(mem_dis_q[31:0],
                                             AVS_WRITEDATA_I, be_mask);
      if (sel_mmh) mem_dis_q[63:32] <= merge(mem_dis_q[63:32],
                                             AVS_WRITEDATA_I, be_mask);
      if (sel_cfg) cfg_q <= merge(cfg_q, AVS_WRITEDATA_I,
                                  be_mask & lwd_pkg::CFG_WMASK);
      if (sel_hb)  hbase_q <= merge(hbase_q, AVS_WRITEDATA_I, be_mask);
    end
  end

  // Preset reloads 002Eh on system reset and is written only by software
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      preset_q <= lwd_pkg::RST_PRESET;
    end else if (wr_stb && sel_pre) begin
      preset_q <= pre_mrg[15:0];
    end
  end

  // Host-side reset is synchronised; a load pulse at its assertion
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hrst_q     <= 2'b11;
      load_q     <= 1'b0;
      load_val_q <= lwd_pkg::RST_PRESET;
    end else begin
      hrst_q <= {hrst_q[0], HOST_RESET_N_I};
      load_q <= 1'b0;
      if (hrst_q[1] & ~hrst_q[0]) begin
        load_q     <= 1'b1;
        load_val_q <= preset_q;
      end
    end
  end

  assign CFG_BASE_LOAD_O = load_q;
  assign CFG_BASE_VAL_O  = load_val_q;

  // Per-device claim gating
  for (genvar i = 0; i < NUM_DEV; i++) begin : g_dev
    assign IO_CLAIM_EN_O[i]  = IO_VALID_I[i] & ~io_dis_q[i];
    assign MEM_CLAIM_EN_O[i] = MEM_VALID_I[i] &
                               ~(mem_dis_q[i] & DEV_PRESENT_I[i]);
  end

  // Memory window translation
  wire [3:0]  win_size  = cfg_q[lwd_pkg::CFG_SIZE_LSB +: lwd_pkg::CFG_SIZE_W];
  wire        win_inh   = cfg_q[lwd_pkg::CFG_INHIBIT];
  wire [31:0] ahb_base  = {cfg_q[31:lwd_pkg::CFG_BASE_LSB],
                           8'h00};
  wire [31:0] low_mask  = (32'h0000_0001 << win_size) - 32'h0000_0001;
  wire        size_ok   = win_size <= lwd_pkg::SIZE_MAX;
  wire        hit       = ((MEM_REQ_I.addr ^ hbase_q) & ~low_mask) ==
                          32'h0000_0000;
  wire [31:0] xlat      = (ahb_base & ~low_mask) |
                          (MEM_REQ_I.addr & low_mask);

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rsp_q <= '0;
    end else begin
      rsp_q.claim    <= MEM_REQ_I.valid & hit & size_ok & ~win_inh;
      rsp_q.ahb_addr <= xlat;
    end
  end

  assign MEM_RSP_O = rsp_q;

endmodule

// ==== testbench/lwd_decode_ctrl_sva.sv ====
`timescale 1ns/1ps
module lwd_sva_chk #(
  parameter int NUM_DEV = 64
) (
  // Watched ports of the decode block
  input wire logic               CORE_CLK_I,
  input wire logic               RST_I,
  input wire logic               HOST_RESET_N_I,
  input wire logic               AVS_READ_I,
  input wire logic               AVS_WRITE_I,
  input wire logic               AVS_WAITREQUEST_O,
  input wire logic [NUM_DEV-1:0] IO_VALID_I,
  input wire logic [NUM_DEV-1:0] MEM_VALID_I,
  input wire logic [NUM_DEV-1:0] DEV_PRESENT_I,
  input wire logic [NUM_DEV-1:0] IO_CLAIM_EN_O,
  input wire logic [NUM_DEV-1:0] MEM_CLAIM_EN_O,
  input wire logic               CFG_BASE_LOAD_O,
  input wire lwd_pkg::lwd_mreq_t MEM_REQ_I,
  input wire lwd_pkg::lwd_mrsp_t MEM_RSP_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Gating, reserved devices, window answer and preset load timing
  AST_IO_GATE: assert property ((IO_CLAIM_EN_O & ~IO_VALID_I) == '0)
    else $error("io claim without valid flag");
  AST_MEM_GATE: assert property ((MEM_CLAIM_EN_O & ~MEM_VALID_I) == '0)
    else $error("mem claim without valid flag");
  AST_MEM_RSVD: assert property
    (((MEM_CLAIM_EN_O ^ MEM_VALID_I) & ~DEV_PRESENT_I) == '0)
    else $error("mask acts on reserved device");
  AST_CLAIM_REQ: assert property
    (MEM_RSP_O.claim |-> $past(MEM_REQ_I.valid))
    else $error("claim without request");
  AST_WAIT_ONE: assert property
    ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("more than one wait state");
  AST_WAIT_FIRST: assert property ($rose(AVS_READ_I) |-> AVS_WAITREQUEST_O)
    else $error("read answered without wait state");
  AST_LOAD_PULSE: assert property
    (CFG_BASE_LOAD_O |=> !CFG_BASE_LOAD_O)
    else $error("load pulse too long");
  AST_LOAD_AFTER: assert property
    ($fell(HOST_RESET_N_I) |-> ##[1:4] CFG_BASE_LOAD_O)
    else $error("no load after host reset");
endmodule
bind lwd_decode_ctrl lwd_sva_chk #(.NUM_DEV(NUM_DEV)) u_chk (
  .CORE_CLK_I, .RST_I, .HOST_RESET_N_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_WAITREQUEST_O, .IO_VALID_I, .MEM_VALID_I, .DEV_PRESENT_I,
  .IO_CLAIM_EN_O, .MEM_CLAIM_EN_O, .CFG_BASE_LOAD_O, .MEM_REQ_I, .MEM_RSP_O
);

// ==== testbench/lwd_host_model.sv ====
`timescale 1ns/1ps
module lwd_host_model (
  // Clock and memory cycle request
  input  wire logic          clk,
  output lwd_pkg::lwd_mreq_t req
);
  initial req = '0;
  // One memory cycle; afterwards the address lines show the inverse
  task cyc(input logic [31:0] a);
    @(posedge clk);
    req <= {1'b1, a};
    @(posedge clk);
    req <= {1'b0, ~a};
  endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, hrst_n = 1, rd = 0, wr = 0, wait_q, ld;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, got;
  logic [63:0] iov = 64'hFFFF_FFFF_FFFF_FFFF, memv = 64'hFFFF_FFFF_FFFF_FFFF;
  logic [63:0] pres = 64'h0000_0000_FFFF_FFFF, ioc, memc;
  logic [15:0] bval;
  logic [7:0]  offs [6] = '{8'h20, 8'h24, 8'h40, 8'h44, 8'hFC, 8'h10};
  lwd_pkg::lwd_mreq_t mreq;
  lwd_pkg::lwd_mrsp_t mrsp;
  int bad_count = 0, n_tests = 0;
  // Clock, design and host model
  always #2.5 clk = ~clk;
  lwd_decode_ctrl dut (.CORE_CLK_I(clk), .RST_I(rst), .HOST_RESET_N_I(hrst_n),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wait_q), .IO_VALID_I(iov), .MEM_VALID_I(memv),
    .DEV_PRESENT_I(pres), .IO_CLAIM_EN_O(ioc), .MEM_CLAIM_EN_O(memc),
    .CFG_BASE_LOAD_O(ld), .CFG_BASE_VAL_O(bval), .MEM_REQ_I(mreq),
    .MEM_RSP_O(mrsp));
  lwd_host_model host (.clk(clk), .req(mreq));
  // Compare, bus access and window cycle tasks
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (wait_q === 1'b0) break;
    end
    @(posedge clk);
    got = rdat;
    if (i == 20) bad_count++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk({32'h0000_0000, got}, {32'h0000_0000, e});
  endtask
  task win(input logic [31:0] a, input logic c, input logic [31:0] e);
    host.cyc(a);
    #1;
    chk({63'h0, mrsp.claim}, {63'h0, c});
    if (c) chk({32'h0000_0000, mrsp.ahb_addr}, {32'h0000_0000, e});
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) rdc(offs[i], 32'h0000_0000);
    rdc(8'h30, 32'h0000_002E);
    chk({48'h0, bval}, 64'h0000_0000_0000_002E);
    $display("test reset done");
    bus(1'b1, 8'h20, 32'h8000_0001);
    bus(1'b1, 8'h24, 32'h0000_0002);
    rdc(8'h24, 32'h0000_0002);
    chk(ioc, ~64'h0000_0002_8000_0001);
    $display("test io mask done");
    bus(1'b1, 8'h40, 32'h0000_0003);
    bus(1'b1, 8'h44, 32'h0000_0001);
    rdc(8'h44, 32'h0000_0001);
    chk(memc, 64'hFFFF_FFFF_FFFF_FFFC);
    memv <= 64'hFFFF_FFFF_FFFF_FFEF;
    @(posedge clk);
    #1 chk(memc, 64'hFFFF_FFFF_FFFF_FFEC);
    $display("test mem mask done");
    bus(1'b1, 8'h30, 32'h0000_1234);
    hrst_n <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      if (ld === 1'b1) break;
    end
    chk({47'h0, ld, bval}, {47'h0, 1'b1, 16'h1234});
    hrst_n <= 1'b1;
    $display("test preset done");
    bus(1'b1, 8'h50, 32'h000C_0000);
    bus(1'b1, 8'hFC, 32'h0012_300C);
    win(32'h000C_0ABC, 1'b1, 32'h0012_3ABC);
    win(32'h000D_0ABC, 1'b0, 32'h0000_0000);
    bus(1'b1, 8'hFC, 32'h0012_308C);
    win(32'h000C_0ABC, 1'b0, 32'h0000_0000);
    bus(1'b1, 8'hFC, 32'h0012_3000);
    win(32'h000C_0000, 1'b1, 32'h0012_3000);
    win(32'h000C_0001, 1'b0, 32'h0000_0000);
    bus(1'b1, 8'hFC, 32'h0012_300D);
    win(32'h000C_0ABC, 1'b0, 32'h0000_0000);
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rdc(8'hFC, 32'hFFFF_FF8F);
    $display("test window done");
    end_of_test();
  end
endmodule
